// [logic/fbmc_match_counter.sv]
/*
 * forty-bit loadable match counter with wishbone register access.
 * assumes clk_i at 10 MHz, synchronous active-high rst_i, a classic
 * wishbone master, and timekeeper_clock_in_i asynchronous and much
 * slower than clk_i (under half its rate).
 */
// Local design decisions: the address map and the Wishbone register port.
// How it works
// - forty-bit loadable upward counting timekeeper
// - divide timekeeper clock by 128 first
// - each register location holds one byte
// - writing counter bytes presets the counter
// - counter reads return coherent read-hold snapshot
// - fabric match flag high while equal
// - sequencer match flag mirrors fabric flag
// - match sets match-bits register all ones
// - auto-clear counter to zero on match
// - no auto-clear when match value zero
// - oscillator mode output from mode field
// - mode-source select from oscillator enable bit
// - byte-wide register port, clock at most 10MHz
`timescale 1ns/1ns
`default_nettype none
`include "fbmc_defs.svh"

module fbmc_match_counter #(
   parameter int DIV = `FBMC_PRESCALE
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone classic slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [9:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // timekeeper clock from the oscillator output pin
   input wire logic timekeeper_clock_in_i,
   // match flags and oscillator controls
   output logic fabric_match_flag_o,
   output logic sequencer_match_flag_o,
   output logic [1:0] osc_mode_out_o,
   output logic osc_mode_source_sel_o,
   // level interrupt
   output logic irq_o
);

   localparam int W = `FBMC_CNT_W;

   fbmc_pkg::fbmc_state_t q, d;   // registered state and its next value

   logic tk_edge;      // rising edge of synchronised timekeeper clock
   logic tick;         // one prescaled tick
   logic [7:0] idx;    // register index from the word address
   logic req;          // new bus request, not yet acknowledged
   logic wr;           // write taking effect at this edge
   logic [7:0] wb;     // written byte
   logic hit_clear;    // counter reached match with auto-clear allowed
   logic wrap;         // counter rolls over from all ones
   logic [2:0] bsel;   // byte number within a forty-bit register

   // edge of the timekeeper clock, seen only past the second flop
   assign tk_edge = q.sync[1] & ~q.sync[2];

   // prescaler turns timekeeper edges into counter ticks
   fbmc_prescaler #(
      .DIV(DIV)
   ) u_psc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .edge_i(tk_edge),
      .tick_o(tick)
   );

   // bus decode: one byte per word, data in the low lane
   assign idx = adr_i[9:2];
   assign req = cyc_i & stb_i & ~q.ack;
   assign wr = cyc_i & stb_i & we_i & q.ack & sel_i[0];
   assign wb = dat_i[7:0];
   assign bsel = idx[2:0];

   // auto-clear only when enabled and the match value is not zero
   assign hit_clear = (q.cnt == q.match) &
                      q.ctrl[`FBMC_CTRL_AUTO_CLR] &
                      (q.match != '0);
   assign wrap = &q.cnt;

   // next-state logic for the counter, registers and bus answer
   always_comb begin
      d = q;

      // two-flop synchroniser plus one flop for edge detection
      d.sync = {q.sync[1:0], timekeeper_clock_in_i};

      // counter advances once per prescaled tick
      if (tick) begin
         if (hit_clear) begin
            d.cnt = '0;
         end else begin
            d.cnt = q.cnt + W'(1);
         end
      end

      // acknowledge one cycle after the request, drop the next
      d.ack = req;

      // read data and snapshot are taken in the request cycle
      if (req & ~we_i) begin
         d.dat = 8'h00;
         if (idx >= `FBMC_IDX_CNT0 && idx <= `FBMC_IDX_CNT4) begin
            if (idx == `FBMC_IDX_CNT0) begin
               // first byte snapshots all forty bits
               d.hold = q.cnt;
               d.dat = q.cnt[7:0];
            end else begin
               d.dat = q.hold[bsel*8 +: 8];
            end
         end else if (idx >= `FBMC_IDX_MAT0 &&
                      idx < `FBMC_IDX_MAT4 + 8'h01) begin
            d.dat = q.match[bsel*8 +: 8];
         end else if (idx == `FBMC_IDX_CTRL) begin
            // live equality shown in the status bit
            d.dat = q.ctrl;
            d.dat[`FBMC_CTRL_MATCH] = q.matchf;
         end else if (idx == `FBMC_IDX_IRQ_STAT) begin
            d.dat = {6'h00, q.stat};
         end else if (idx == `FBMC_IDX_IRQ_MASK) begin
            d.dat = {6'h00, q.mask};
         end else if (idx >= `FBMC_IDX_MBIT0 &&
                      idx <= `FBMC_IDX_MBIT4) begin
            d.dat = q.mbits[bsel*8 +: 8];
         end
      end

      // writes land at the acknowledge edge; a load beats a tick
      if (wr) begin
         if (idx >= `FBMC_IDX_CNT0 && idx <= `FBMC_IDX_CNT4) begin
            d.cnt[bsel*8 +: 8] = wb;
         end else if (idx >= `FBMC_IDX_MAT0 &&
                      idx < `FBMC_IDX_MAT4 + 8'h01) begin
            d.match[bsel*8 +: 8] = wb;
         end else if (idx == `FBMC_IDX_CTRL) begin
            // status bit is read-only
            d.ctrl = wb;
            d.ctrl[`FBMC_CTRL_MATCH] = 1'b0;
         end else if (idx == `FBMC_IDX_IRQ_STAT) begin
            // write one to clear
            d.stat = q.stat & ~wb[1:0];
         end else if (idx == `FBMC_IDX_IRQ_MASK) begin
            d.mask = wb[1:0];
         end else if (idx >= `FBMC_IDX_MBIT0 &&
                      idx <= `FBMC_IDX_MBIT4) begin
            // software clears match bits byte by byte
            d.mbits[bsel*8 +: 8] = q.mbits[bsel*8 +: 8] & ~wb;
         end
      end

      // compare the full width on the updated values
      d.matchf = (d.cnt == d.match);

      // a new match sets the match bits and status; set wins over clear
      if (d.matchf & ~q.matchf) begin
         d.mbits = '1;
         d.stat[`FBMC_IRQ_MATCH] = 1'b1;
      end

      // rollover of the counter is an event too
      if (tick & ~hit_clear & wrap) begin
         d.stat[`FBMC_IRQ_WRAP] = 1'b1;
      end
   end

   // register the whole state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.ctrl <= `FBMC_CTRL_RST;
         q.mask <= `FBMC_MASK_RST;
         q.match <= `FBMC_MATCH_RST;
         // counter and match both reset to zero, so they start equal
         q.matchf <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // bus outputs: byte in the low lane, upper bits zero
   assign dat_o = {24'h000000, q.dat};
   assign ack_o = q.ack;

   // match flags straight from the equality flop
   assign fabric_match_flag_o = q.matchf;
   assign sequencer_match_flag_o = q.matchf;

   // oscillator controls from the control register
   assign osc_mode_out_o = q.ctrl[`FBMC_CTRL_MODE_LO +: 2];
   assign osc_mode_source_sel_o = q.ctrl[`FBMC_CTRL_OSC_EN];

   // level interrupt while any unmasked status bit stands
   assign irq_o = |(q.stat & q.mask);

endmodule : fbmc_match_counter

`default_nettype wire

// [logic/fbmc_defs.svh]
/*
 * constants of the forty-bit match counter: register indexes, field
 * positions, reset values and the prescaler ratio.
 * assumes it is included by bare name from the package and design files.
 */
`ifndef FBMC_DEFS_SVH
`define FBMC_DEFS_SVH

// counter width and prescaler ratio
`define FBMC_CNT_W 40
`define FBMC_PRESCALE 128

// register indexes; byte address on the bus is four times the index
`define FBMC_IDX_CNT0 8'h40
`define FBMC_IDX_CNT4 8'h44
`define FBMC_IDX_MAT0 8'h48
`define FBMC_IDX_MAT4 8'h4c
`define FBMC_IDX_CTRL 8'h4d
`define FBMC_IDX_IRQ_STAT 8'h4e
`define FBMC_IDX_IRQ_MASK 8'h4f
`define FBMC_IDX_MBIT0 8'h50
`define FBMC_IDX_MBIT4 8'h54

// control and status register fields
`define FBMC_CTRL_MODE_LO 0
`define FBMC_CTRL_OSC_EN 2
`define FBMC_CTRL_AUTO_CLR 3
`define FBMC_CTRL_MATCH 7

// interrupt status and mask bit positions
`define FBMC_IRQ_MATCH 0
`define FBMC_IRQ_WRAP 1

// reset values
`define FBMC_CTRL_RST 8'h00
`define FBMC_MASK_RST 2'h0
`define FBMC_MATCH_RST 40'h00_0000_0000

`endif

// [logic/fbmc_pkg.sv]
/*
 * types of the forty-bit match counter.
 * assumes fbmc_defs.svh is on the include path.
 */
`default_nettype none
`include "fbmc_defs.svh"

package fbmc_pkg;

   // whole state of the counter block
   typedef struct packed {
      logic [2:0] sync;                  // timekeeper clock synchroniser
      logic [`FBMC_CNT_W-1:0] cnt;       // live counter
      logic [`FBMC_CNT_W-1:0] hold;      // read-hold snapshot
      logic [`FBMC_CNT_W-1:0] match;     // match value
      logic [`FBMC_CNT_W-1:0] mbits;     // match-bits register
      logic [7:0] ctrl;                  // control and status
      logic [1:0] stat;                  // sticky interrupt status
      logic [1:0] mask;                  // interrupt mask
      logic matchf;                      // equality flag
      logic ack;                         // bus acknowledge
      logic [7:0] dat;                   // read data byte
   } fbmc_state_t;

endpackage : fbmc_pkg

`default_nettype wire

// [logic/fbmc_prescaler.sv]
/*
 * divide-by-n prescaler: emits a one-cycle tick on every n-th input edge.
 * assumes edge_i is a one-cycle pulse on clk_i, already synchronised.
 */
`timescale 1ns/1ns
`default_nettype none
`include "fbmc_defs.svh"

module fbmc_prescaler #(
   parameter int DIV = `FBMC_PRESCALE
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic edge_i,
   output logic tick_o
);

   localparam int CW = $clog2(DIV);

   // state of the divider
   typedef struct packed {
      logic [CW-1:0] cnt;   // edges seen in this period
      logic tick;           // period complete
   } fbmc_psc_t;

   fbmc_psc_t q, d;

   // count edges and wrap after DIV of them
   always_comb begin
      d = q;
      d.tick = 1'b0;
      if (edge_i) begin
         if (q.cnt == CW'(DIV - 1)) begin
            d.cnt = '0;
            d.tick = 1'b1;
         end else begin
            d.cnt = q.cnt + CW'(1);
         end
      end
   end

   // register the state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick_o = q.tick;

endmodule : fbmc_prescaler

`default_nettype wire

// [dv/fbmc_osc_model.sv]
/* crystal oscillator output model feeding the timekeeper clock pin.
   assumes run_i is driven by the bench; output rests low when idle. */
`timescale 1ns/1ns
`default_nettype none

module fbmc_osc_model (
   input wire logic run_i,
   output logic clk_o
);
   // one 600 ns period per loop, parked low between bursts
   initial begin
      clk_o = 1'b0;
      forever begin
         wait (run_i);
         #280 clk_o = 1'b1;
         #320 clk_o = 1'b0;
      end
   end
endmodule : fbmc_osc_model

`default_nettype wire

// [dv/fbmc_chk.sv]
/* checker on the match counter ports: bus timing, flags, controls.
   assumes it is bound to the counter top; one clock, sync reset. */
`timescale 1ns/1ns
`default_nettype none

module fbmc_chk #(
   parameter int DIV = 128
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [9:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic timekeeper_clock_in_i,
   input wire logic fabric_match_flag_o,
   input wire logic sequencer_match_flag_o,
   input wire logic [1:0] osc_mode_out_o,
   input wire logic osc_mode_source_sel_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic ctl_wr; // a ctrl write is being acknowledged
   assign ctl_wr = ack_o && we_i && sel_i[0] && adr_i[9:2] == 8'h4d;

   a_seq_mirror: assert property (
      sequencer_match_flag_o == fabric_match_flag_o)
      else $error("match flags differ");
   a_ack_once: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_next: assert property (
      cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack not one cycle after request");
   a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   a_byte_wide: assert property (ack_o |-> dat_o[31:8] == 24'h0)
      else $error("read data wider than a byte");
   a_unmapped_zero: assert property (
      ack_o && !we_i && adr_i[9:2] > 8'h54 |-> dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_ctrl_read: assert property (
      ack_o && !we_i && adr_i[9:2] == 8'h4d |->
      dat_o[2:0] == {osc_mode_source_sel_o, osc_mode_out_o})
      else $error("ctrl read differs from osc outputs");
   a_osc_cause: assert property (
      $changed({osc_mode_out_o, osc_mode_source_sel_o}) |->
      $past(ctl_wr) || $past(ctl_wr, 2))
      else $error("osc controls moved without a ctrl write");
endmodule : fbmc_chk

`default_nettype wire

// [dv/fbmc_match_counter_tb.sv]
/* bench for the match counter: bus, counting, match, irq.
   assumes design, oscillator model and checker compiled first. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin \
 miscompares++; $display("ERROR %s exp %h got %h", n, e, a); end end

module fbmc_match_counter_tb;
   localparam int DIV = 4; // short prescale
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
   logic we_i = 1'b0, run = 1'b0, tk, ack_o, irq_o, fm, sm, osel;
   logic [9:0] adr_i = 10'h000;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic [1:0] mode;
   logic [39:0] v;
   int compares = 0, miscompares = 0;

   always #50 clk_i = ~clk_i; // 10 MHz
   fbmc_osc_model u_fbmc_osc_model (.run_i(run), .clk_o(tk));
   fbmc_match_counter #(.DIV(DIV)) u_fbmc_match_counter (.clk_i, .rst_i,
      .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .timekeeper_clock_in_i(tk), .fabric_match_flag_o(fm),
      .sequencer_match_flag_o(sm), .osc_mode_out_o(mode),
      .osc_mode_source_sel_o(osel), .irq_o);

   // one classic cycle, held until ack under a bound
   task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, sel_i} <= {2'b11, w, 4'h1};
      adr_i <= {i, 2'b00};
      dat_i <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      rd = dat_o;
      if (n >= 20) begin
         miscompares++;
         tally_and_finish();
      end
      {cyc_i, stb_i} <= 2'b00;
   endtask : wb

   // five byte writes, lowest first; rd40 also reads the lowest first so the snapshot is taken
   task automatic wr40(input logic [7:0] i, input logic [39:0] d);
      for (int k = 0; k < 5; k++) wb(1'b1, i + 8'(k), d[8*k +: 8]);
   endtask : wr40

   task automatic rd40(input logic [7:0] i);
      for (int k = 0; k < 5; k++) begin
         wb(1'b0, i + 8'(k), 8'h00);
         v[8*k +: 8] = rd[7:0];
      end
   endtask : rd40

   // let the oscillator run for n prescaled periods, then settle
   task automatic ticks(input int n);
      @(posedge clk_i);
      run <= 1'b1;
      repeat (n * DIV * 6 - 1) @(posedge clk_i);
      run <= 1'b0;
      repeat (10) @(posedge clk_i);
   endtask : ticks

   task automatic t_ctrl();
      for (int m = 0; m < 8; m++) begin
         wb(1'b1, 8'h4d, 8'(m));
         repeat (2) @(posedge clk_i);
         `CHK("mode", 2'(m), mode)
         `CHK("srcsel", m[2], osel)
      end
      wb(1'b1, 8'h4d, 8'h00);
      wb(1'b0, 8'h60, 8'h00);
      `CHK("unmapped", 32'h0, rd)
   endtask : t_ctrl

   task automatic t_match();
      wr40(8'h48, 40'h5);
      wr40(8'h40, 40'h12_3456_789a);
      rd40(8'h40);
      `CHK("load", 40'h12_3456_789a, v)
      wr40(8'h40, 40'h3);
      wr40(8'h50, 40'hff_ffff_ffff);
      wb(1'b1, 8'h4e, 8'h03);
      ticks(2);
      `CHK("fabric", 1'b1, fm)
      `CHK("seq", 1'b1, sm)
      rd40(8'h40);
      `CHK("count", 40'h5, v)
      rd40(8'h50);
      `CHK("mbits", 40'hff_ffff_ffff, v)
      wb(1'b1, 8'h4f, 8'h01);
      repeat (2) @(posedge clk_i);
      `CHK("irq on", 1'b1, irq_o)
      wb(1'b1, 8'h4e, 8'h01);
      repeat (2) @(posedge clk_i);
      `CHK("irq off", 1'b0, irq_o)
      wb(1'b1, 8'h4f, 8'h00);
      wb(1'b1, 8'h4d, 8'h08);
      ticks(1);
      rd40(8'h40);
      `CHK("autoclr", 40'h0, v)
      `CHK("fabric", 1'b0, fm)
   endtask : t_match

   task automatic t_zero();
      wr40(8'h48, 40'h0);
      wr40(8'h40, 40'hff_ffff_ffff);
      wb(1'b1, 8'h4e, 8'h03);
      ticks(2);
      rd40(8'h40);
      `CHK("zero match", 40'h1, v)
      wb(1'b0, 8'h4e, 8'h00);
      `CHK("status", 8'h03, rd[7:0])
   endtask : t_zero

   task automatic tally_and_finish();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish

   // main sequence after a three cycle reset
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      `CHK("reset flag", 1'b1, fm)
      `CHK("reset irq", 1'b0, irq_o)
      t_ctrl();
      t_match();
      t_zero();
      tally_and_finish();
   end

   // watchdog against a hung bus or counter
   initial begin
      #3000000;
      miscompares++;
      tally_and_finish();
   end
endmodule : fbmc_match_counter_tb

bind fbmc_match_counter fbmc_chk #(.DIV(DIV)) u_chk (.clk_i, .rst_i, .cyc_i,
   .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
   .timekeeper_clock_in_i, .fabric_match_flag_o, .sequencer_match_flag_o,
   .osc_mode_out_o, .osc_mode_source_sel_o, .irq_o);

`default_nettype wire
